/* flash_seq_defines.svh */
// command codes, address layout and timing constants of the flash sequencer
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH
`define WRITE_ENABLE_CMD 8'h06
`define SECTOR_ERASE_CMD 8'h20
`define BLOCK_ERASE_CMD 8'hD8
`define CHIP_ERASE_CMD 8'h60
`define CHIP_ERASE_ALT_CMD 8'hC7
`define PAGE_PROGRAM_CMD 8'h02
`define DEEP_POWERDOWN_CMD 8'hB9
`define RELEASE_POWERDOWN_CMD 8'hAB
`define LEGACY_SIGNATURE_CMD `RELEASE_POWERDOWN_CMD
`define READ_IDENTIFICATION_CMD 8'h9F
`define MAKER_DEVICE_CODE_CMD 8'h90
`define MAKER_DEVICE_CODE_ALT_CMD 8'hEF
`define DEVICE_FIRST_ADDR 8'h01
`define ADDR_BITS 24
`define SECTOR_LSB 12
`define BLOCK_LSB 16
`define PAGE_LSB 8
`define HEADER_BYTES 3'h4
`define CLK_MHZ 20
`define CLK_PERIOD_NS 50
`define SECTOR_ERASE_TIME_US 60000
`define BLOCK_ERASE_TIME_US 700000
`define CHIP_ERASE_TIME_US 9000000
`define PAGE_PROGRAM_TIME_US 1400
`define POWERDOWN_ENTRY_DELAY_NS 10000
`define POWERDOWN_RELEASE_DELAY_NS 8800
`define POWERDOWN_ENTRY_CYCLES ((`POWERDOWN_ENTRY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERDOWN_RELEASE_CYCLES (`POWERDOWN_RELEASE_DELAY_NS / `CLK_PERIOD_NS)
`endif

/* flash_seq_pkg.sv */
// types shared by the flash sequencer
package flash_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_STREAM = 3'h2,
    ST_TIMED = 3'h4
  } op_state_e;
  typedef enum logic [1:0] {
    ERASE_SECTOR = 2'h0,
    ERASE_BLOCK = 2'h1,
    ERASE_CHIP = 2'h2
  } erase_kind_e;
endpackage

/* flash_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module flash_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign agree = ~(s2 ^ s3);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      level <= RESET_VAL;
    end else begin
      level <= (agree & s3) | (~agree & level);
    end
  end

  assign rise = agree & s3 & ~level;
  assign fall = agree & ~s3 & level;
endmodule

/* flash_two_entry_buffer.sv */
// small valid/ready buffer decoupling the program stream from the array
`timescale 1ns/100ps
module flash_two_entry_buffer #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* flash_sequencer.sv */
// serial flash erase, program, power-down and identification command logic
//
// Contract
// - sector erase sets one 4K-byte sector to ones, needs latch set first
// - sector chosen by address bits from the top down to bit 12
// - erase/program end on byte boundary after last address byte, else rejected
// - sector erase self-timed on select rise; busy held, latch cleared; protected skipped
// - block erase sets one 64K-byte block to ones, needs latch set
// - block erase self-timed on select rise; busy then latch clear; protected skipped
// - chip erase self-timed on select rise; busy held; latch cleared at end
// - chip erase runs only when all protect bits are zero
// - page program clears bits; needs latch; select held low whole transfer
// - program data past page end wraps to page start
// - over 256 bytes: only the last 256 are programmed
// - under 256 bytes: only addressed bytes of the page change
// - page program self-timed on select rise; busy, latch clear; protected skipped
// - in deep power-down only release and signature commands act
// - deep power-down entered a fixed delay after select rise
// - power-down commands end exactly after eighth opcode bit, else ignored
// - release immediate if awake, else after release delay
// - signature byte repeats while clocked; ends on select rise after one readout
// - release and signature ignored while a busy cycle runs
// - identification gives one maker byte, two device bytes; not while busy
// - maker/device code: opcode, two dummy bytes, address byte, then MSB first
// - address byte one gives device code first, then alternates
`timescale 1ns/100ps
`include "flash_seq_defines.svh"
module flash_sequencer #(
  parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES = `BLOCK_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned CHIP_ERASE_CYCLES = `CHIP_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned PAGE_PROGRAM_CYCLES = `PAGE_PROGRAM_TIME_US * `CLK_MHZ,
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] MEMORY_TYPE_CODE = 8'h11,
  parameter logic [7:0] DENSITY_CODE = 8'h22,
  parameter logic [7:0] SIGNATURE_CODE = 8'h33
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic [3:0] block_protect_bits,
  output logic write_in_progress,
  output logic write_enable_latch,
  output logic deep_powerdown,
  output logic erase_req,
  output flash_seq_pkg::erase_kind_e erase_kind,
  output logic [`ADDR_BITS-1:0] erase_addr,
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [`ADDR_BITS-1:0] prog_addr,
  output logic [7:0] prog_data
);
  localparam int AW = `ADDR_BITS;
  localparam logic [11:0] ENTRY_CYCLES = 12'(`POWERDOWN_ENTRY_CYCLES);
  localparam logic [11:0] RELEASE_CYCLES = 12'(`POWERDOWN_RELEASE_CYCLES);

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic cs_n_s;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic si_s;

  flash_pin_sync #(.W(3), .RESET_VAL(3'h6)) pin_sync (
    .clock(clock),
    .rst(rst),
    .pins({cs_n, sclk, si}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_n_s = pin_level[2];
  assign cs_rise = pin_rise[2];
  assign cs_fall = pin_fall[2];
  assign sclk_rise = pin_rise[1] && !cs_n_s;
  assign sclk_fall = pin_fall[1] && !cs_n_s;
  assign si_s = pin_level[0];

  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [6:0] shift;
  logic [7:0] opcode;
  logic [AW-1:0] addr;
  logic [1:0] out_idx;
  logic byte_done;
  logic [7:0] next_byte;
  flash_seq_pkg::op_state_e state;
  logic [31:0] timer;
  logic [7:0] page_mem [256];
  logic [255:0] page_mask;
  logic [7:0] fill_ptr;
  logic [7:0] scan_idx;
  logic pd_entering;
  logic pd_leaving;
  logic [11:0] pd_timer;
  logic pd_any;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [AW+7:0] buf_out;

  assign byte_done = sclk_rise && bit_cnt == 3'h7;
  assign next_byte = {shift, si_s};
  assign write_in_progress = state != flash_seq_pkg::ST_IDLE;
  assign pd_any = deep_powerdown || pd_entering || pd_leaving;

  // serial framing: bit and byte counters, opcode and address capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shift <= 7'h00;
      opcode <= 8'h00;
      addr <= '0;
    end else if (cs_fall) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= next_byte[6:0];
      if (byte_done && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      if (byte_done && byte_cnt == 3'h0) begin
        opcode <= next_byte;
      end
      // address frozen while a cycle still uses it
      if (byte_done && byte_cnt != 3'h0 && byte_cnt < `HEADER_BYTES && !write_in_progress) begin
        addr <= {addr[AW-9:0], next_byte};
      end
    end
  end

  // page buffer fill; the pointer wraps within the page
  logic prog_op;
  assign prog_op = opcode == `PAGE_PROGRAM_CMD && !write_in_progress;

  always_ff @(posedge clock) begin
    if (byte_done && prog_op && byte_cnt >= `HEADER_BYTES) begin
      page_mem[fill_ptr] <= next_byte;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fill_ptr <= 8'h00;
      page_mask <= '0;
    end else if (cs_fall && !write_in_progress) begin
      page_mask <= '0;
    end else if (byte_done && prog_op) begin
      if (byte_cnt == `HEADER_BYTES - 3'h1) begin
        fill_ptr <= next_byte;
      end else if (byte_cnt >= `HEADER_BYTES) begin
        fill_ptr <= fill_ptr + 8'h01;
        page_mask[fill_ptr] <= 1'b1;
      end
    end
  end

  // command acceptance at the end of a frame
  logic aligned;
  logic can_cmd;
  logic is_chip_erase;
  logic is_maker_code;
  logic wel_go;
  logic erase_go;
  logic prog_go;
  logic dp_go;
  logic rel_go;
  logic target_protected;

  function automatic logic covers(input logic [3:0] bp, input logic [AW-1:0] a);
    logic [8:0] span;
    logic [8:0] blk;
    span = (bp >= 4'h9) ? 9'h100 : 9'(9'h001 << (bp - 4'h1));
    blk = {1'b0, a[AW-1:`BLOCK_LSB]};
    covers = bp != 4'h0 && blk >= 9'h100 - span;
  endfunction

  assign aligned = bit_cnt == 3'h0;
  assign can_cmd = cs_rise && aligned && !write_in_progress && !pd_any;
  assign is_chip_erase = opcode == `CHIP_ERASE_CMD || opcode == `CHIP_ERASE_ALT_CMD;
  assign is_maker_code = opcode == `MAKER_DEVICE_CODE_CMD || opcode == `MAKER_DEVICE_CODE_ALT_CMD;
  assign target_protected = covers(block_protect_bits, addr);
  assign wel_go = can_cmd && byte_cnt == 3'h1 && opcode == `WRITE_ENABLE_CMD;
  assign erase_go = can_cmd && write_enable_latch &&
    (((opcode == `SECTOR_ERASE_CMD || opcode == `BLOCK_ERASE_CMD) && byte_cnt == `HEADER_BYTES && !target_protected)
    || (is_chip_erase && byte_cnt == 3'h1 && block_protect_bits == 4'h0));
  assign prog_go = can_cmd && write_enable_latch && opcode == `PAGE_PROGRAM_CMD &&
    byte_cnt > `HEADER_BYTES && !target_protected;
  assign dp_go = can_cmd && byte_cnt == 3'h1 && opcode == `DEEP_POWERDOWN_CMD;
  assign rel_go = cs_rise && !write_in_progress && opcode == `RELEASE_POWERDOWN_CMD &&
    ((aligned && byte_cnt == 3'h1) || byte_cnt > `HEADER_BYTES);

  // self-timed cycle sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= flash_seq_pkg::ST_IDLE;
      timer <= 32'h0;
      scan_idx <= 8'h00;
      erase_req <= 1'b0;
      erase_kind <= flash_seq_pkg::ERASE_SECTOR;
      erase_addr <= '0;
    end else begin
      erase_req <= 1'b0;
      unique case (state)
        flash_seq_pkg::ST_IDLE: begin
          if (erase_go) begin
            erase_req <= 1'b1;
            state <= flash_seq_pkg::ST_TIMED;
            if (is_chip_erase) begin
              erase_kind <= flash_seq_pkg::ERASE_CHIP;
              erase_addr <= '0;
              timer <= CHIP_ERASE_CYCLES;
            end else if (opcode == `SECTOR_ERASE_CMD) begin
              erase_kind <= flash_seq_pkg::ERASE_SECTOR;
              erase_addr <= {addr[AW-1:`SECTOR_LSB], {`SECTOR_LSB{1'b0}}};
              timer <= SECTOR_ERASE_CYCLES;
            end else begin
              erase_kind <= flash_seq_pkg::ERASE_BLOCK;
              erase_addr <= {addr[AW-1:`BLOCK_LSB], {`BLOCK_LSB{1'b0}}};
              timer <= BLOCK_ERASE_CYCLES;
            end
          end else if (prog_go) begin
            scan_idx <= 8'h00;
            state <= flash_seq_pkg::ST_STREAM;
          end
        end
        flash_seq_pkg::ST_STREAM: begin
          if (!page_mask[scan_idx] || buf_in_ready) begin
            scan_idx <= scan_idx + 8'h01;
            if (scan_idx == 8'hFF) begin
              timer <= PAGE_PROGRAM_CYCLES;
              state <= flash_seq_pkg::ST_TIMED;
            end
          end
        end
        flash_seq_pkg::ST_TIMED: begin
          timer <= timer - 32'h1;
          if (timer <= 32'h1) begin
            state <= flash_seq_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  logic cycle_end;
  assign cycle_end = state == flash_seq_pkg::ST_TIMED && timer <= 32'h1;

  // latch cleared at end of cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (wel_go) begin
      write_enable_latch <= 1'b1;
    end else if (cycle_end) begin
      write_enable_latch <= 1'b0;
    end
  end

  // program data toward the array through the buffer
  assign buf_in_valid = state == flash_seq_pkg::ST_STREAM && page_mask[scan_idx];

  flash_two_entry_buffer #(.W(AW + 8), .DEPTH(2)) prog_buffer (
    .clock(clock),
    .rst(rst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({addr[AW-1:`PAGE_LSB], scan_idx, page_mem[scan_idx]}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(buf_out)
  );

  assign prog_addr = buf_out[AW+7:8];
  assign prog_data = buf_out[7:0];

  // deep power-down entry and release timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deep_powerdown <= 1'b0;
      pd_entering <= 1'b0;
      pd_leaving <= 1'b0;
      pd_timer <= 12'h000;
    end else if (rel_go) begin
      pd_entering <= 1'b0;
      if (deep_powerdown) begin
        pd_leaving <= 1'b1;
        pd_timer <= RELEASE_CYCLES;
      end else begin
        pd_timer <= 12'h000;
      end
    end else if (dp_go) begin
      pd_entering <= 1'b1;
      pd_timer <= ENTRY_CYCLES;
    end else if (pd_timer != 12'h000) begin
      pd_timer <= pd_timer - 12'h001;
      if (pd_timer == 12'h001) begin
        deep_powerdown <= pd_entering;
        pd_entering <= 1'b0;
        pd_leaving <= 1'b0;
      end
    end
  end

  // readout: header length, code rotation and output byte
  logic [2:0] hdr_len;
  logic [1:0] idx_last;
  logic read_ok;
  logic [7:0] out_byte;
  logic out_phase;

  always_comb begin
    hdr_len = `HEADER_BYTES;
    idx_last = 2'h0;
    read_ok = 1'b0;
    out_byte = 8'h00;
    if (opcode == `READ_IDENTIFICATION_CMD) begin
      hdr_len = 3'h1;
      idx_last = 2'h2;
      read_ok = !write_in_progress && !pd_any;
      out_byte = (out_idx == 2'h0) ? MAKER_CODE : (out_idx == 2'h1) ? MEMORY_TYPE_CODE : DENSITY_CODE;
    end else if (is_maker_code) begin
      idx_last = 2'h1;
      read_ok = !write_in_progress && !pd_any;
      out_byte = ((addr[7:0] == `DEVICE_FIRST_ADDR) ^ out_idx[0]) ? SIGNATURE_CODE : MAKER_CODE;
    end else if (opcode == `LEGACY_SIGNATURE_CMD) begin
      read_ok = !write_in_progress;
      out_byte = SIGNATURE_CODE;
    end
  end

  assign out_phase = byte_cnt >= hdr_len && !cs_n_s;
  assign so_oe = out_phase && read_ok;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_idx <= 2'h0;
      so_out <= 1'b0;
    end else if (cs_fall) begin
      out_idx <= 2'h0;
      so_out <= 1'b0;
    end else begin
      if (byte_done && byte_cnt >= hdr_len) begin
        out_idx <= (out_idx == idx_last) ? 2'h0 : out_idx + 2'h1;
      end
      if (sclk_fall && out_phase) begin
        so_out <= out_byte[3'h7 - bit_cnt];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_dp_accept;
    dp_go;
  endsequence
  sequence s_unaligned_end;
    cs_rise && !aligned;
  endsequence

  latch_clear_end_a: assert property ($fell(write_in_progress) |-> !write_enable_latch)
    else $error("latch still set after cycle end");
  busy_needs_latch_a: assert property ($rose(write_in_progress) |-> $past(write_enable_latch))
    else $error("cycle started without latch");
  chip_protect_a: assert property (erase_req && erase_kind == flash_seq_pkg::ERASE_CHIP |->
    $past(block_protect_bits) == 4'h0) else $error("chip erase while protected");
  sector_align_a: assert property (erase_req && erase_kind == flash_seq_pkg::ERASE_SECTOR |->
    erase_addr[11:0] == 12'h000) else $error("sector address not aligned");
  dp_delay_a: assert property (s_dp_accept |=> !deep_powerdown ##1 !deep_powerdown)
    else $error("power-down entered without delay");
  unaligned_reject_a: assert property (s_unaligned_end |=> !$rose(write_in_progress))
    else $error("unaligned frame started a cycle");
  id_busy_quiet_a: assert property (write_in_progress && opcode == `READ_IDENTIFICATION_CMD |-> !so_oe)
    else $error("identification driven while busy");
  stream_busy_a: assert property (state == flash_seq_pkg::ST_STREAM |-> write_in_progress ##1 write_in_progress)
    else $error("busy dropped while streaming");
  pd_cmd_block_a: assert property (deep_powerdown && cs_rise |=> !$rose(write_in_progress))
    else $error("command accepted in power-down");
  release_awake_a: assert property (rel_go && !deep_powerdown |=> !pd_leaving && !deep_powerdown)
    else $error("release from standby not immediate");
endmodule

/* spi_host_model.sv */
// host serial controller model driving the flash pins
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe,
  output logic rx_stb,
  output logic [7:0] rx_byte,
  output logic oe_seen
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    si = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    oe_seen = 1'b0;
  end
  always @(posedge clock) begin
    if (!cs_n && so_oe) begin
      oe_seen <= 1'b1;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic select();
    tick(1);
    oe_seen <= 1'b0;
    cs_n <= 1'b0;
    tick(4);
  endtask
  task automatic deselect(input int gap);
    tick(4);
    cs_n <= 1'b1;
    si <= ~si;
    tick(gap);
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic watch);
    logic [7:0] rx;
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk <= 1'b0;
      si <= tx[i];
      tick(4);
      sclk <= 1'b1;
      tick(2);
      rx[i] = so_out;
      tick(2);
    end
    if (watch) begin
      rx_byte <= rx;
      rx_stb <= 1'b1;
      tick(1);
      rx_stb <= 1'b0;
    end
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the flash sequencer
`timescale 1ns/100ps
`include "flash_seq_defines.svh"
module tb_top;
  localparam int unsigned SE_C = 200;
  localparam int unsigned BE_C = 300;
  localparam int unsigned CE_C = 400;
  localparam int unsigned PP_C = 500;
  // arbitrary identification values
  localparam logic [7:0] MK = 8'h3C;
  localparam logic [7:0] TY = 8'h41;
  localparam logic [7:0] DN = 8'h52;
  localparam logic [7:0] SG = 8'h67;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] block_protect_bits = 4'h0;
  logic prog_ready = 1'b0;
  logic stall = 1'b1;
  logic [7:0] lf = 8'h4F;
  logic [7:0] seed = 8'h4F;
  logic cs_n, sclk, si, so_out, so_oe, rx_stb, oe_seen;
  logic write_in_progress, write_enable_latch, deep_powerdown, erase_req, prog_valid;
  logic [7:0] rx_byte, prog_data;
  logic [23:0] erase_addr, prog_addr;
  flash_seq_pkg::erase_kind_e erase_kind;
  logic [35:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  always #25 clock = ~clock;
  spi_host_model host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si), .so_out(so_out), .so_oe(so_oe),
    .rx_stb(rx_stb), .rx_byte(rx_byte), .oe_seen(oe_seen));
  flash_sequencer #(.SECTOR_ERASE_CYCLES(SE_C), .BLOCK_ERASE_CYCLES(BE_C), .CHIP_ERASE_CYCLES(CE_C),
    .PAGE_PROGRAM_CYCLES(PP_C), .MAKER_CODE(MK), .MEMORY_TYPE_CODE(TY), .DENSITY_CODE(DN),
    .SIGNATURE_CODE(SG)) DUT (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so_out(so_out), .so_oe(so_oe), .block_protect_bits(block_protect_bits),
    .write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
    .deep_powerdown(deep_powerdown), .erase_req(erase_req), .erase_kind(erase_kind),
    .erase_addr(erase_addr), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_addr(prog_addr), .prog_data(prog_data));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // array side stalls at random
  always @(posedge clock) begin
    lf <= lfsr(lf);
    prog_ready <= !stall && lf[0];
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    check({35'h0, s}, {35'h0, e});
  endtask
  task automatic take(input logic [35:0] seen);
    if (exp_q.size() == 0) check(seen, {4'hF, 32'h0});
    else check(seen, exp_q.pop_front());
  endtask
  // results are matched against the oldest note
  always @(posedge clock) begin
    if (rx_stb) take({4'h1, 24'h0, rx_byte});
    if (erase_req) take({4'h2, 6'h0, erase_kind, erase_addr});
    if (prog_valid && prog_ready) take({4'h3, prog_addr, prog_data});
  end
  task automatic pb(input logic [7:0] b);
    exp_q.push_back({4'h1, 24'h0, b});
  endtask
  task automatic frame(input logic [7:0] q[$], input int extra, input int nrd, input int gap);
    host.select();
    foreach (q[k]) host.xfer(q[k], 8, 1'b0);
    if (extra > 0) host.xfer(8'hFF, extra, 1'b0);
    repeat (nrd) host.xfer(8'h00, 8, 1'b1);
    host.deselect(gap);
  endtask
  task automatic write_enable_cmd();
    frame('{`WRITE_ENABLE_CMD}, 0, 0, 8);
    chk1(write_enable_latch, 1'b1);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress && n < 5000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic erase_run(input logic [7:0] cmd, input logic [23:0] a, input logic [1:0] k,
    input logic [23:0] base, input int cyc);
    logic [7:0] q[$];
    int n;
    q = '{cmd, a[23:16], a[15:8], a[7:0]};
    if (k == flash_seq_pkg::ERASE_CHIP) q = '{cmd};
    write_enable_cmd();
    exp_q.push_back({4'h2, 6'h0, k, base});
    frame(q, 0, 0, 2);
    n = 0;
    while (!write_in_progress && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    while (write_in_progress && n < 1000) begin
      n++;
      tick(1);
    end
    check(36'(n), 36'(cyc));
    chk1(write_enable_latch, 1'b0);
  endtask
  task automatic pp_run(input logic [23:0] a, input int nb);
    logic [7:0] q[$];
    int last[256];
    q = '{`PAGE_PROGRAM_CMD, a[23:16], a[15:8], a[7:0]};
    foreach (last[i]) last[i] = -1;
    for (int k = 0; k < nb; k++) begin
      seed = lfsr(seed);
      q.push_back(seed);
      last[(int'(a[7:0]) + k) % 256] = k;
    end
    for (int i = 0; i < 256; i++) begin
      if (last[i] >= 0) exp_q.push_back({4'h3, a[23:8], 8'(i), q[4 + last[i]]});
    end
    write_enable_cmd();
    stall <= 1'b1;
    frame(q, 0, 0, 2);
    tick(40);
    stall <= 1'b0;
    wait_idle();
    chk1(write_enable_latch, 1'b0);
  endtask
  task automatic tally_and_finish();
    check(36'(exp_q.size()), 36'h0);
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #4000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(6);
    frame('{`SECTOR_ERASE_CMD, 8'h01, 8'h23, 8'h45}, 0, 0, 8);
    chk1(write_in_progress, 1'b0);
    erase_run(`SECTOR_ERASE_CMD, 24'h012345, flash_seq_pkg::ERASE_SECTOR, 24'h012000, SE_C);
    erase_run(`BLOCK_ERASE_CMD, 24'h0ABCDE, flash_seq_pkg::ERASE_BLOCK, 24'h0A0000, BE_C);
    erase_run(`CHIP_ERASE_CMD, 24'h0, flash_seq_pkg::ERASE_CHIP, 24'h0, CE_C);
    erase_run(`CHIP_ERASE_ALT_CMD, 24'h0, flash_seq_pkg::ERASE_CHIP, 24'h0, CE_C);
    $display("test erase ended");
    write_enable_cmd();
    frame('{`SECTOR_ERASE_CMD, 8'h00, 8'h10, 8'h00}, 3, 0, 8);
    chk1(write_in_progress, 1'b0);
    block_protect_bits <= 4'h9;
    frame('{`SECTOR_ERASE_CMD, 8'h00, 8'h10, 8'h00}, 0, 0, 8);
    chk1(write_in_progress, 1'b0);
    frame('{`PAGE_PROGRAM_CMD, 8'h00, 8'h00, 8'h00, 8'hAA}, 0, 0, 8);
    chk1(write_in_progress, 1'b0);
    block_protect_bits <= 4'h1;
    frame('{`CHIP_ERASE_CMD}, 0, 0, 8);
    chk1(write_in_progress, 1'b0);
    block_protect_bits <= 4'h0;
    $display("test refusal ended");
    pp_run(24'h0001FE, 4);
    pp_run(24'h000200, 258);
    $display("test program ended");
    write_enable_cmd();
    exp_q.push_back({4'h2, 6'h0, flash_seq_pkg::ERASE_BLOCK, 24'h150000});
    frame('{`BLOCK_ERASE_CMD, 8'h15, 8'h00, 8'h00}, 0, 0, 2);
    host.select();
    host.xfer(`READ_IDENTIFICATION_CMD, 8, 1'b0);
    host.xfer(8'h00, 8, 1'b0);
    host.deselect(2);
    chk1(oe_seen, 1'b0);
    chk1(write_in_progress, 1'b1);
    wait_idle();
    pb(MK);
    pb(TY);
    pb(DN);
    pb(MK);
    frame('{`READ_IDENTIFICATION_CMD}, 0, 4, 8);
    pb(SG);
    pb(MK);
    pb(SG);
    frame('{`MAKER_DEVICE_CODE_CMD, 8'h00, 8'h00, `DEVICE_FIRST_ADDR}, 0, 3, 8);
    pb(MK);
    pb(SG);
    frame('{`MAKER_DEVICE_CODE_ALT_CMD, 8'h00, 8'h00, 8'h00}, 0, 2, 8);
    pb(SG);
    frame('{`LEGACY_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00}, 0, 1, 8);
    chk1(deep_powerdown, 1'b0);
    $display("test identification ended");
    frame('{`DEEP_POWERDOWN_CMD}, 4, 0, 210);
    chk1(deep_powerdown, 1'b0);
    frame('{`DEEP_POWERDOWN_CMD}, 0, 0, 190);
    chk1(deep_powerdown, 1'b0);
    tick(20);
    chk1(deep_powerdown, 1'b1);
    frame('{`WRITE_ENABLE_CMD}, 0, 0, 8);
    chk1(write_enable_latch, 1'b0);
    pb(SG);
    pb(SG);
    frame('{`LEGACY_SIGNATURE_CMD, 8'h00, 8'h00, 8'h00}, 0, 2, 190);
    chk1(deep_powerdown, 1'b0);
    frame('{`DEEP_POWERDOWN_CMD}, 0, 0, 210);
    frame('{`RELEASE_POWERDOWN_CMD}, 0, 0, 190);
    chk1(deep_powerdown, 1'b0);
    $display("test powerdown ended");
    tally_and_finish();
  end
endmodule
